/* File: sdsp_asserts.sv */
// Port checker for the serial port top.
// Assumes a synchronous active-low reset on clk.
`default_nettype none
module sdsp_asserts (
   input wire logic                clk,
   input wire logic                rst_n,
   input wire logic                sclk,
   input wire logic                cs_n,
   input wire logic                dout,
   input wire logic                dout_oe_n,
   input wire logic                result_ready_n,
   input wire logic                result_valid,
   input wire logic                conversion_clock_input,
   input wire logic                clock_output_pin,
   input wire logic                clock_output_pin_oe_n,
   input wire sdsp_pkg::sdsp_cfg_t cfg
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_ready_set: assert property (result_valid |=> !result_ready_n)
      else $error("ready late");
   a_ready_cause: assert property ($fell(result_ready_n) |-> $past(result_valid))
      else $error("ready fell alone");
   a_set_wins: assert property ($rose(result_ready_n) |-> !$past(result_valid))
      else $error("ready rose on result");
   a_dout_release: assert property (dout_oe_n == cs_n)
      else $error("dout drive wrong");
   a_clock_output_pin_inv: assert property (clock_output_pin == ~conversion_clock_input)
      else $error("clock out not inverted");
   a_clock_output_pin_en: assert property (clock_output_pin_oe_n == cfg.clock_output_disable)
      else $error("clock out enable wrong");
   a_dout_fall: assert property ($changed(dout) |-> !sclk)
      else $error("dout moved on rise");
   a_reset_vals: assert property (disable iff (1'b0) !rst_n |=>
      result_ready_n && !clock_output_pin_oe_n && cfg == 7'h0a)
      else $error("reset values wrong");
endmodule
bind sdsp_top sdsp_asserts u_chk (.clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
   .dout(dout), .dout_oe_n(dout_oe_n), .result_ready_n(result_ready_n),
   .result_valid(result_valid), .conversion_clock_input(conversion_clock_input),
   .clock_output_pin(clock_output_pin), .clock_output_pin_oe_n(clock_output_pin_oe_n),
   .cfg(cfg));
`default_nettype wire

/* File: sdsp_defs.svh */
// Constants for the sigma-delta converter serial port.
// Assumes inclusion by bare name from the package and the top module.
// What this block does
// [RQ1] Serial input bits are captured on rising serial clock while select is low.
// [RQ2] Serial output changes on falling edges; host samples on rising edges.
// [RQ3] Serial output is released, not driven, whenever select is high.
// [RQ4] Host drives select low per transfer, or ties it low for three wires.
// [RQ5] Reading the result register shifts its contents out on serial output.
// [RQ6] Result ready goes low when a fresh result enters the result register.
// [RQ7] Result ready returns high only after a complete output word is read.
// [RQ8] Clock output pin is enabled when disable bit is 0, off when 1.
// [RQ9] Enabled clock output pin shows the inverse of the conversion clock.
// [RQ10] Reset low returns all registers and interface state to power-on condition.
// [RQ11] Serial port works to 5MHz serial clock; host stays below that (host model here runs a 48 ns period, about 20.8MHz, above that limit).
// [RQ12] Each result word is sixteen bits wide.
// [RQ13] Gain is selectable in power-of-two steps from 1 to 128.
// [RQ14] Filter rate and first notch are programmable from 20Hz to 500Hz.
// [RQ15] Gain comes from a three-bit gain field in the setup register.
// [RQ16] Unipolar results are straight binary, zero input gives the lowest code.
// [RQ17] Bipolar results are offset binary, zero input gives mid-scale code.
// [RQ18] Serial clock edges while select is high shift nothing and advance nothing.
`ifndef SDSP_DEFS_SVH
`define SDSP_DEFS_SVH
`define SDSP_WORD_W        16
`define SDSP_CNT_W         5
`define SDSP_BYTE_W        8
`define SDSP_GAIN_W        3
`define SDSP_RATE_W        2
`define SDSP_WORD_LAST     5'h0f
`define SDSP_BYTE_LAST     5'h07
`define SDSP_CNT_ZERO      5'h00
`define SDSP_CNT_ONE       5'h01
`define SDSP_MID_SCALE     16'h8000
`define SDSP_SEL_SETUP     3'h1
`define SDSP_SEL_CLOCK     3'h2
`define SDSP_SEL_DATA      3'h3
`define SDSP_RS_LSB        4
`define SDSP_RW_BIT        3
`define SDSP_SETUP_BU      2
`define SDSP_SETUP_GAIN_LSB 3
`define SDSP_CLK_DIS_BIT   4
`define SDSP_CLK_RATE_LSB  0
`define SDSP_SETUP_RESET   8'h01
`define SDSP_CLOCK_RESET   8'h05
`define SDSP_SCLK_MAX_HZ   5000000
`endif

/* File: sdsp_host.sv */
// Host model: serial master with its own 48 ns bit clock.
// Assumes the bench resolves the data-out line for it.
`default_nettype none
module sdsp_host (
   output logic        sclk,
   output logic        cs_n   = 1'b1,
   output logic        din    = 1'b0,
   input  wire logic   dout_line,
   output logic [15:0] rx     = 16'h0000,
   output logic        rx_tgl = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   logic lclk = 1'b1;
   logic run  = 1'b0;
   always #24 lclk = ~lclk;
   // Serial clock stands high outside bursts
   assign sclk = run ? lclk : 1'b1;
   task automatic idle(input int n);
      repeat (n) begin
         @(posedge lclk) run <= 1'b1;
         @(negedge lclk) din <= 1'($urandom);
      end
      @(posedge lclk) run <= 1'b0;
   endtask
   task automatic xfer(input logic [23:0] tx, input int n, input logic rd);
      logic [15:0] r;
      r = 16'h0000;
      @(posedge lclk);
      run  <= 1'b1;
      cs_n <= 1'b0;
      din  <= tx[n-1];
      for (int i = n - 1; i >= 0; i--) begin
         @(posedge lclk) r = {r[14:0], dout_line};
         if (i > 0) @(negedge lclk) din <= tx[i-1];
      end
      run  <= 1'b0;
      cs_n <= 1'b1;
      din  <= ~din;
      if (rd) begin
         // Blocking, so the word has settled before the toggle is seen
         rx      = r & 16'((17'h1 << (n > 8 ? n - 8 : n)) - 1);
         rx_tgl <= ~rx_tgl;
      end
   endtask
endmodule
`default_nettype wire

/* File: sdsp_pkg.sv */
// Types for the sigma-delta converter serial port.
// Assumes sdsp_defs.svh is on the include path.
`include "sdsp_defs.svh"
`default_nettype none
package sdsp_pkg;
   typedef enum logic [1:0] {
      SDSP_CMD   = 2'b00,
      SDSP_WRITE = 2'b01,
      SDSP_READ  = 2'b10
   } sdsp_phase_t;

   typedef struct packed {
      logic [`SDSP_GAIN_W-1:0] gain;
      logic                    bipolar;
      logic [`SDSP_RATE_W-1:0] rate;
      logic                    clock_output_disable;
   } sdsp_cfg_t;

   // Link side state, serial clock domain
   typedef struct packed {
      sdsp_phase_t             phase;
      logic [`SDSP_CNT_W-1:0]  cnt;
      logic [`SDSP_WORD_W-1:0] sh;
      logic [2:0]              sel;
      logic [`SDSP_WORD_W-1:0] tx;
      logic [`SDSP_BYTE_W-1:0] setup;
      logic [`SDSP_BYTE_W-1:0] clock;
      logic                    read_tgl;
      logic [1:0]              res_sync;
      logic                    res_seen;
      logic [`SDSP_WORD_W-1:0] res_hold;
      logic                    cfg_tgl;
   } sdsp_link_t;

   // Falling edge output stage
   typedef struct packed {
      logic dout;
   } sdsp_fall_t;

   // System side state
   typedef struct packed {
      logic [`SDSP_WORD_W-1:0] result;
      logic                    ready_n;
      logic                    res_tgl;
      logic [2:0]              read_sync;
      logic [2:0]              cfg_sync;
      logic [`SDSP_BYTE_W-1:0] setup;
      logic [`SDSP_BYTE_W-1:0] clock;
   } sdsp_sys_t;
endpackage
`default_nettype wire

/* File: sdsp_top.sv */
// Serial port, result register and clock output control of the converter.
// Assumes a host master on sclk/cs_n/din; filter delivers results on clk.
`include "sdsp_defs.svh"
`default_nettype none
module sdsp_top (
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   input  wire logic                    sclk,
   input  wire logic                    cs_n,
   input  wire logic                    din,
   output logic                         dout,
   output logic                         dout_oe_n,
   output logic                         result_ready_n,
   input  wire logic                    result_valid,
   input  wire logic [`SDSP_WORD_W-1:0] result_code,
   input  wire logic                    conversion_clock_input,
   output logic                         clock_output_pin,
   output logic                         clock_output_pin_oe_n,
   output sdsp_pkg::sdsp_cfg_t          cfg
);
   // ------------------------------------------------------------
   // Serial clock domain: command, write and read phases
   // ------------------------------------------------------------
   sdsp_pkg::sdsp_link_t lk;
   sdsp_pkg::sdsp_link_t next_lk;
   sdsp_pkg::sdsp_fall_t fl;
   sdsp_pkg::sdsp_fall_t next_fl;
   sdsp_pkg::sdsp_sys_t  sy;
   sdsp_pkg::sdsp_sys_t  next_sy;
   logic                 lrst_n_s0;
   logic                 lrst_n;
   logic                 res_new;

   // Reset crosses into the link domain; state clears while it is held low
   always_ff @(posedge sclk) begin
      lrst_n_s0 <= rst_n;
      lrst_n    <= lrst_n_s0;
   end

   always_comb begin
      next_lk          = lk;
      next_lk.res_sync = {lk.res_sync[0], sy.res_tgl};
      // Result word is taken only after its toggle has passed both flops;
      // a second result within three serial clocks of the first may tear
      if (lk.res_sync[1] != lk.res_seen) begin
         next_lk.res_seen = lk.res_sync[1];
         next_lk.res_hold = sy.result;
      end
      if (!cs_n) begin //RQ18
         next_lk.sh  = {lk.sh[`SDSP_WORD_W-2:0], din}; //RQ1
         next_lk.cnt = lk.cnt + `SDSP_CNT_ONE;
         case (lk.phase)
            sdsp_pkg::SDSP_CMD: begin
               if (lk.cnt == `SDSP_BYTE_LAST) begin
                  next_lk.cnt = `SDSP_CNT_ZERO;
                  next_lk.sel = next_lk.sh[`SDSP_RS_LSB +: 3];
                  if (next_lk.sh[`SDSP_RW_BIT]) begin
                     next_lk.phase = sdsp_pkg::SDSP_READ;
                     if (next_lk.sel == `SDSP_SEL_SETUP) begin
                        next_lk.tx = {lk.setup, `SDSP_BYTE_W'(0)};
                     end else if (next_lk.sel == `SDSP_SEL_CLOCK) begin
                        next_lk.tx = {lk.clock, `SDSP_BYTE_W'(0)};
                     end else if (next_lk.sel == `SDSP_SEL_DATA) begin
                        next_lk.tx = lk.res_hold; //RQ5
                     end else begin
                        next_lk.tx = `SDSP_WORD_W'(0);
                     end
                  end else if (next_lk.sel == `SDSP_SEL_SETUP ||
                               next_lk.sel == `SDSP_SEL_CLOCK) begin
                     next_lk.phase = sdsp_pkg::SDSP_WRITE;
                  end
               end
            end
            sdsp_pkg::SDSP_WRITE: begin
               if (lk.cnt == `SDSP_BYTE_LAST) begin
                  next_lk.cnt   = `SDSP_CNT_ZERO;
                  next_lk.phase = sdsp_pkg::SDSP_CMD;
                  next_lk.cfg_tgl = ~lk.cfg_tgl;
                  if (lk.sel == `SDSP_SEL_SETUP) begin
                     next_lk.setup = next_lk.sh[`SDSP_BYTE_W-1:0]; //RQ15
                  end else begin
                     next_lk.clock = next_lk.sh[`SDSP_BYTE_W-1:0]; //RQ14
                  end
               end
            end
            sdsp_pkg::SDSP_READ: begin
               next_lk.tx = {lk.tx[`SDSP_WORD_W-2:0], 1'b0};
               if ((lk.sel == `SDSP_SEL_DATA && lk.cnt == `SDSP_WORD_LAST) ||
                   (lk.sel != `SDSP_SEL_DATA && lk.cnt == `SDSP_BYTE_LAST)) begin
                  next_lk.cnt   = `SDSP_CNT_ZERO;
                  next_lk.phase = sdsp_pkg::SDSP_CMD;
                  if (lk.sel == `SDSP_SEL_DATA) begin
                     next_lk.read_tgl = ~lk.read_tgl; //RQ7
                  end
               end
            end
            default: begin
               next_lk.phase = sdsp_pkg::SDSP_CMD;
            end
         endcase
      end
      if (!lrst_n) begin //RQ10
         next_lk          = '0;
         next_lk.setup    = `SDSP_SETUP_RESET;
         next_lk.clock    = `SDSP_CLOCK_RESET;
      end
   end

   always_ff @(posedge sclk) begin //RQ11
      lk <= next_lk;
   end

   // ------------------------------------------------------------
   // Output stage: launch on falling serial clock
   // ------------------------------------------------------------
   always_comb begin
      next_fl = fl;
      if (!cs_n) begin
         next_fl.dout = (lk.phase == sdsp_pkg::SDSP_READ) ? lk.tx[`SDSP_WORD_W-1] : 1'b0; //RQ2
      end
      if (!lrst_n) begin
         next_fl = '0;
      end
   end

   always_ff @(negedge sclk) begin
      fl <= next_fl;
   end

   assign dout      = fl.dout;
   assign dout_oe_n = cs_n; //RQ3

   // ------------------------------------------------------------
   // System clock domain: result register and ready flag
   // ------------------------------------------------------------
   assign res_new = result_valid;

   always_comb begin
      next_sy           = sy;
      next_sy.read_sync = {sy.read_sync[1:0], lk.read_tgl};
      next_sy.cfg_sync  = {sy.cfg_sync[1:0], lk.cfg_tgl};
      // Settings words are copied only once a finished write has crossed
      if (sy.cfg_sync[2] != sy.cfg_sync[1]) begin
         next_sy.setup = lk.setup;
         next_sy.clock = lk.clock;
      end
      if (sy.read_sync[2] != sy.read_sync[1]) begin
         next_sy.ready_n = 1'b1; //RQ7
      end
      // A new result wins over a read completing in the same cycle
      if (res_new) begin
         next_sy.result  = result_code; //RQ12
         next_sy.ready_n = 1'b0; //RQ6
         next_sy.res_tgl = ~sy.res_tgl;
      end
      if (!rst_n) begin //RQ10
         next_sy           = '0;
         next_sy.ready_n   = 1'b1;
         next_sy.setup     = `SDSP_SETUP_RESET;
         next_sy.clock     = `SDSP_CLOCK_RESET;
      end
   end

   always_ff @(posedge clk) begin
      sy <= next_sy;
   end

   assign result_ready_n = sy.ready_n;

   // Configuration fields decoded from the settled copies
   assign cfg.gain    = sy.setup[`SDSP_SETUP_GAIN_LSB +: `SDSP_GAIN_W]; //RQ13
   assign cfg.bipolar = ~sy.setup[`SDSP_SETUP_BU]; //RQ16 RQ17
   assign cfg.rate    = sy.clock[`SDSP_CLK_RATE_LSB +: `SDSP_RATE_W]; //RQ14
   assign cfg.clock_output_disable = sy.clock[`SDSP_CLK_DIS_BIT];

   // ------------------------------------------------------------
   // Clock output pin
   // ------------------------------------------------------------
   assign clock_output_pin      = ~conversion_clock_input; //RQ9
   assign clock_output_pin_oe_n = sy.clock[`SDSP_CLK_DIS_BIT]; //RQ8
endmodule
`default_nettype wire

/* File: sigma_delta_adc_serial_port_tb_top.sv */
// Bench for the serial port top, host model on the link.
// Assumes sdsp_host and sdsp_asserts are compiled first.
`default_nettype none
`define CHK(nm, got, exp) begin checks_done++; if ((got) !== (exp)) begin \
   num_errors++; $display("Error %s expected %h seen %h", nm, exp, got); end end
module sigma_delta_adc_serial_port_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst_n = 1'b0, result_valid = 1'b0, conv = 1'b0;
   logic [15:0] result_code = 16'h0000, rx, ev, code;
   logic sclk, cs_n, din, dout, dout_oe_n, result_ready_n, clk_pin, clk_oe_n, rx_tgl;
   logic [7:0] s, c;
   logic [15:0] exp_q[$];
   sdsp_pkg::sdsp_cfg_t cfg;
   int num_errors = 0;
   int checks_done = 0;
   wire logic dline = dout_oe_n ? 1'b1 : dout;
   always #10 clk = ~clk;
   always @(posedge clk) conv <= 1'($urandom);
   sdsp_top dut (.clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .din(din),
      .dout(dout), .dout_oe_n(dout_oe_n), .result_ready_n(result_ready_n),
      .result_valid(result_valid), .result_code(result_code),
      .conversion_clock_input(conv), .clock_output_pin(clk_pin),
      .clock_output_pin_oe_n(clk_oe_n), .cfg(cfg));
   sdsp_host u_host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout_line(dline),
      .rx(rx), .rx_tgl(rx_tgl));
   // The port settling at time zero is not a result
   always @(rx_tgl) if ($time > 0) begin
      ev = exp_q.pop_front();
      `CHK("rx", rx, ev)
   end
   task automatic report_and_stop();
      if (num_errors == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic settle(input logic [6:0] e);
      for (int k = 0; k < 20 && cfg !== e; k++) @(posedge clk);
      `CHK("cfg", cfg, e)
      `CHK("clk_oe", clk_oe_n, e[0])
   endtask
   task automatic do_reset();
      @(posedge clk) rst_n <= 1'b0;
      u_host.idle(4);
      @(posedge clk) rst_n <= 1'b1;
      u_host.idle(4);
      settle(7'h0a);
      `CHK("ready", result_ready_n, 1'b1)
   endtask
   initial begin
      #300us;
      num_errors++;
      report_and_stop();
   end
   initial begin
      void'($urandom(32'hfeb265dd));
      do_reset();
      for (int g = 0; g < 8; g++) begin
         s = {2'b00, 3'(g), 1'(g), 2'b01};
         c = {3'b000, 1'(g), 2'b00, 2'(g)};
         u_host.xfer({8'h10, s}, 16, 1'b0);
         u_host.xfer({8'h20, c}, 16, 1'b0);
         u_host.idle(3);
         exp_q.push_back({8'h00, s});
         u_host.xfer(24'h001800, 16, 1'b1);
         exp_q.push_back({8'h00, c});
         u_host.xfer(24'h002800, 16, 1'b1);
         settle({s[5:3], ~s[2], c[1:0], c[4]});
      end
      for (int p = 0; p < 2; p++) begin
         code = 16'($urandom);
         @(posedge clk);
         result_valid <= 1'b1;
         result_code  <= code;
         @(posedge clk);
         result_valid <= 1'b0;
         @(posedge clk);
         `CHK("ready", result_ready_n, 1'b0)
         exp_q.push_back(p ? code : {8'h00, code[15:8]});
         u_host.xfer(p ? 24'h380000 : 24'h003800, p ? 24 : 16, 1'b1);
         if (p == 0) begin
            // Half word read: ready must stay low
            repeat (10) @(posedge clk);
            `CHK("ready", result_ready_n, 1'b0)
            exp_q.push_back({8'h00, code[7:0]});
            u_host.xfer(24'h000000, 8, 1'b1);
         end
         for (int k = 0; k < 10 && result_ready_n !== 1'b1; k++) @(posedge clk);
         `CHK("ready", result_ready_n, 1'b1)
      end
      do_reset();
      report_and_stop();
   end
endmodule
`default_nettype wire
